// ===== stc_consts.svh
// constants of the sixteen-bit timer/counter: offsets, fields, resets, timing
// assumes inclusion by its bare name from the modules and the bench alike
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define STC_OFF_CTRL 8'h00
`define STC_OFF_LOW 8'h04
`define STC_OFF_HIGH 8'h08
`define STC_OFF_STATUS 8'h0C
`define STC_OFF_MASK 8'h10
`define STC_OFF_PORT 8'h14

// ----------------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------------
`define STC_BIT_WIDE 7
`define STC_BIT_TB_HI 6
`define STC_BIT_PS_HI 5
`define STC_BIT_PS_LO 4
`define STC_BIT_TB_LO 3
`define STC_BIT_SYNC 2
`define STC_BIT_SRC 1
`define STC_BIT_RUN 0

// ----------------------------------------------------------------------
// port register fields and status bit
// ----------------------------------------------------------------------
`define STC_BIT_OVF 0
`define STC_PORT_DIR_LO 0
`define STC_PORT_OUT_LO 2
`define STC_PORT_IN_LO 4

// ----------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------
`define STC_RST_CTRL 8'h00
`define STC_RST_DIR 2'h3
`define STC_RST_MASK 1'b0
`define STC_COUNT_MAX 16'hFFFF
`define STC_COUNT_ZERO 16'h0000

// ----------------------------------------------------------------------
// timing: instruction clock is the system clock divided by four
// ----------------------------------------------------------------------
`define STC_PCLK_HZ 10000000
`define STC_INSTR_DIV 4

`endif

// ===== stc_pkg.sv
// types shared by the timer/counter modules
// assumes stc_consts.svh is on the include path
package stc_pkg;

    // ------------------------------------------------------------------
    // operating modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        STC_MODE_TIMER = 2'b00,
        STC_MODE_SYNC = 2'b01,
        STC_MODE_ASYNC = 2'b10
    } stc_mode_t;

    // ------------------------------------------------------------------
    // pin drive carrier for the two oscillator-shared pins
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] out;
        logic [1:0] oe;
    } stc_pins_t;

    // ------------------------------------------------------------------
    // complete state of the top module
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] count;
        logic [7:0] hi_buf;
        logic [2:0] presc;
        logic armed;
        logic ext_prev;
        logic edge_pend;
        logic ovf_flag;
        logic ovf_mask;
        logic [1:0] port_dir;
        logic [1:0] port_out;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        stc_pins_t pins;
        logic tb_ccp1;
        logic tb_ccp2;
    } stc_state_t;

endpackage

// ===== stc_clk_div.sv
// clock-enable divider: one-cycle tick every DIV clocks
// assumes a single clock; DIV of at least 2
`timescale 1ns/100ps
module stc_clk_div
    import stc_pkg::*;
#(
    parameter int DIV = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } stc_div_t;

    stc_div_t div_reg;
    stc_div_t div_next;

    // ------------------------------------------------------------------
    // divider
    // ------------------------------------------------------------------
    always_comb begin
        div_next = div_reg;
        div_next.tick = 1'b0;
        if (div_reg.cnt == 8'(DIV - 1)) begin
            div_next.cnt = 8'h00;
            div_next.tick = 1'b1;
        end else begin
            div_next.cnt = div_reg.cnt + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    assign tick = div_reg.tick;

endmodule

// ===== stc_sync.sv
// two-flop synchroniser for a bundle of asynchronous levels
// assumes inputs change independently; no bus coherence is given
`timescale 1ns/100ps
module stc_sync
    import stc_pkg::*;
#(
    parameter int W = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
    } stc_sync_t;

    stc_sync_t sync_reg;
    stc_sync_t sync_next;

    // ------------------------------------------------------------------
    // two stages; only the second stage is read outside
    // ------------------------------------------------------------------
    always_comb begin
        sync_next.ff1 = d;
        sync_next.ff2 = sync_reg.ff1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign q = sync_reg.ff2;

endmodule

// ===== stc_timer.sv
// sixteen-bit timer/counter with APB register access
// assumes an APB master on pclk; pins and oscillator arrive asynchronously
`timescale 1ns/100ps
`include "stc_consts.svh"

module stc_timer
    import stc_pkg::*;
#(
    parameter int INSTR_DIV = `STC_INSTR_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic [1:0] pin_in,
    input wire logic osc_clk_in,
    input wire logic companion_osc_enable,
    input wire logic ccp1_special_trigger,
    input wire logic ccp2_special_trigger,
    output stc_pins_t pin_drive,
    output logic [15:0] count_value,
    output logic ccp1_timebase_this,
    output logic ccp2_timebase_this
);

    stc_state_t st_reg;
    stc_state_t st_next;

    logic instr_tick;
    logic [2:0] async_in;
    logic [2:0] sync_in;

    // ------------------------------------------------------------------
    // instruction clock enable and input synchronisers
    // ------------------------------------------------------------------
    stc_clk_div #(
        .DIV(INSTR_DIV)
    ) i_stc_clk_div (
        .pclk(pclk),
        .presetn(presetn),
        .tick(instr_tick)
    );

    assign async_in = {osc_clk_in, pin_in};

    stc_sync #(
        .W(3)
    ) i_stc_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(async_in),
        .q(sync_in)
    );

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic ext_lvl;
        logic rise;
        logic fall;
        logic cnt_evt;
        logic inc;
        logic ovf_set;
        logic trig;
        logic setup;
        logic wr;
        logic wide;
        logic [2:0] ps_mask;
        logic [1:0] tb;
        logic [1:0] pin_rd;
        stc_mode_t mode;

        st_next = st_reg;
        ext_lvl = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        cnt_evt = 1'b0;
        inc = 1'b0;
        ovf_set = 1'b0;
        trig = 1'b0;
        ps_mask = 3'h0;
        tb = 2'h0;
        pin_rd = 2'h0;
        mode = STC_MODE_TIMER;
        setup = psel && !penable;
        wr = psel && penable && pwrite && st_reg.pready;
        wide = st_reg.ctrl[`STC_BIT_WIDE];

        // external source: oscillator when enabled, else the count pin
        ext_lvl = companion_osc_enable ? sync_in[2] : sync_in[0];
        rise = ext_lvl && !st_reg.ext_prev;
        fall = !ext_lvl && st_reg.ext_prev;
        st_next.ext_prev = ext_lvl;

        case ({st_reg.ctrl[`STC_BIT_SRC], st_reg.ctrl[`STC_BIT_SYNC]})
            2'b00, 2'b01: mode = STC_MODE_TIMER;
            2'b10: mode = STC_MODE_SYNC;
            2'b11: mode = STC_MODE_ASYNC;
            default: mode = STC_MODE_TIMER;
        endcase

        // armed only after a falling edge once external is chosen
        if (mode == STC_MODE_TIMER) begin
            st_next.armed = 1'b0;
        end else if (fall) begin
            st_next.armed = 1'b1;
        end

        case (mode)
            STC_MODE_TIMER: begin
                cnt_evt = instr_tick;
                st_next.edge_pend = 1'b0;
            end
            STC_MODE_SYNC: begin
                // edge held until the next instruction cycle boundary
                if (instr_tick) begin
                    cnt_evt = st_reg.edge_pend || (rise && st_reg.armed);
                    st_next.edge_pend = 1'b0;
                end else if (rise && st_reg.armed) begin
                    st_next.edge_pend = 1'b1;
                end
            end
            STC_MODE_ASYNC: begin
                cnt_evt = rise && st_reg.armed;
                st_next.edge_pend = 1'b0;
            end
            default: begin
                cnt_evt = 1'b0;
                st_next.edge_pend = 1'b0;
            end
        endcase

        // prescaler: ratio 1, 2, 4 or 8
        case (st_reg.ctrl[`STC_BIT_PS_HI:`STC_BIT_PS_LO])
            2'b00: ps_mask = 3'h0;
            2'b01: ps_mask = 3'h1;
            2'b10: ps_mask = 3'h3;
            2'b11: ps_mask = 3'h7;
            default: ps_mask = 3'h0;
        endcase

        if (st_reg.ctrl[`STC_BIT_RUN] && cnt_evt) begin
            if (st_reg.presc >= ps_mask) begin
                st_next.presc = 3'h0;
                inc = 1'b1;
            end else begin
                st_next.presc = st_reg.presc + 3'h1;
            end
        end

        if (inc) begin
            st_next.count = st_reg.count + 16'h0001;
            ovf_set = (st_reg.count == `STC_COUNT_MAX);
        end

        // time base selection: 1x both units, 01 unit two only
        tb = {st_reg.ctrl[`STC_BIT_TB_HI], st_reg.ctrl[`STC_BIT_TB_LO]};
        st_next.tb_ccp1 = tb[1];
        st_next.tb_ccp2 = tb[1] || tb[0];

        // reset may fail unsynchronised, so the trigger is ignored there
        trig = ((ccp1_special_trigger && st_reg.tb_ccp1)
            || (ccp2_special_trigger && st_reg.tb_ccp2))
            && (mode != STC_MODE_ASYNC);
        if (trig) begin
            st_next.count = `STC_COUNT_ZERO;
            ovf_set = 1'b0;
        end

        // ----------------------------------------------------------------
        // register reads, taken in the setup cycle
        // ----------------------------------------------------------------
        pin_rd = companion_osc_enable ? 2'h0 : sync_in[1:0];
        st_next.pready = setup;
        st_next.pslverr = 1'b0;
        if (setup) begin
            st_next.prdata = 32'h0000_0000;
            case (paddr)
                `STC_OFF_CTRL: st_next.prdata[7:0] = st_reg.ctrl;
                `STC_OFF_LOW: begin
                    st_next.prdata[7:0] = st_reg.count[7:0];
                    if (wide && !pwrite) begin
                        st_next.hi_buf = st_reg.count[15:8];
                    end
                end
                `STC_OFF_HIGH: begin
                    st_next.prdata[7:0] = wide ? st_reg.hi_buf : st_reg.count[15:8];
                end
                `STC_OFF_STATUS: st_next.prdata[`STC_BIT_OVF] = st_reg.ovf_flag;
                `STC_OFF_MASK: st_next.prdata[`STC_BIT_OVF] = st_reg.ovf_mask;
                `STC_OFF_PORT: begin
                    st_next.prdata[`STC_PORT_DIR_LO +: 2] = st_reg.port_dir;
                    st_next.prdata[`STC_PORT_OUT_LO +: 2] = st_reg.port_out;
                    st_next.prdata[`STC_PORT_IN_LO +: 2] = pin_rd;
                end
                default: st_next.pslverr = 1'b1;
            endcase
        end

        // ----------------------------------------------------------------
        // register writes, taken at the completing access edge
        // ----------------------------------------------------------------
        if (wr) begin
            case (paddr)
                `STC_OFF_CTRL: st_next.ctrl = pwdata[7:0];
                `STC_OFF_LOW: begin
                    // a write overrides a coincident trigger
                    if (wide) begin
                        st_next.count = {st_reg.hi_buf, pwdata[7:0]};
                    end else begin
                        st_next.count = {st_reg.count[15:8], pwdata[7:0]};
                    end
                    st_next.presc = 3'h0;
                end
                `STC_OFF_HIGH: begin
                    if (wide) begin
                        st_next.hi_buf = pwdata[7:0];
                    end else begin
                        st_next.count = {pwdata[7:0], st_reg.count[7:0]};
                    end
                end
                `STC_OFF_MASK: st_next.ovf_mask = pwdata[`STC_BIT_OVF];
                `STC_OFF_PORT: begin
                    st_next.port_dir = pwdata[`STC_PORT_DIR_LO +: 2];
                    st_next.port_out = pwdata[`STC_PORT_OUT_LO +: 2];
                end
                default: st_next.ovf_mask = st_next.ovf_mask;
            endcase
        end

        // sticky flag: a new overflow wins over a write-one clear
        if (wr && paddr == `STC_OFF_STATUS && pwdata[`STC_BIT_OVF]) begin
            st_next.ovf_flag = 1'b0;
        end
        if (ovf_set) begin
            st_next.ovf_flag = 1'b1;
        end
        st_next.irq = st_next.ovf_flag && st_next.ovf_mask;

        // direction bit one means input, as does an enabled oscillator
        st_next.pins.out = st_next.port_out;
        st_next.pins.oe = ~st_next.port_dir & ~{2{companion_osc_enable}};
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.ctrl <= `STC_RST_CTRL;
            st_reg.port_dir <= `STC_RST_DIR;
            st_reg.ovf_mask <= `STC_RST_MASK;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign irq = st_reg.irq;
    assign pin_drive = st_reg.pins;
    assign count_value = st_reg.count;
    assign ccp1_timebase_this = st_reg.tb_ccp1;
    assign ccp2_timebase_this = st_reg.tb_ccp2;

endmodule

// ===== stc_timer_checker.sv
// assertion checker for the timer/counter port, bound onto stc_timer
// assumes one clock; control and mask are shadowed from apb writes
`timescale 1ns/100ps
`include "stc_consts.svh"
module stc_timer_checker
    import stc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic companion_osc_enable,
    input wire logic ccp1_special_trigger,
    input wire logic ccp2_special_trigger,
    input wire stc_pins_t pin_drive,
    input wire logic [15:0] count_value,
    input wire logic ccp1_timebase_this,
    input wire logic ccp2_timebase_this
);
    // ------------------------------------------------------------------
    // shadow of software writes
    // ------------------------------------------------------------------
    logic [7:0] ctrl_sh;
    logic mask_sh;
    wire logic wr = psel && penable && pready && pwrite;
    wire logic wr_cnt = wr && (paddr == `STC_OFF_LOW || paddr == `STC_OFF_HIGH);
    wire logic trig = ccp1_special_trigger || ccp2_special_trigger;
    wire logic hit = (ccp1_special_trigger && ccp1_timebase_this)
        || (ccp2_special_trigger && ccp2_timebase_this);
    wire logic setup = psel && !penable;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_sh <= 8'h00;
            mask_sh <= 1'b0;
        end else if (wr && paddr == `STC_OFF_CTRL) begin
            ctrl_sh <= pwdata[7:0];
        end else if (wr && paddr == `STC_OFF_MASK) begin
            mask_sh <= pwdata[0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    property p_ready;
        setup |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready not one cycle after setup");
    property p_err;
        setup && (paddr > 8'h14 || paddr[1:0] != 2'b00) |=> pslverr && pready;
    endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_tb;
        ccp1_timebase_this == $past(ctrl_sh[6])
            && ccp2_timebase_this == $past(ctrl_sh[6] || ctrl_sh[3]);
    endproperty
    a_tb: assert property (p_tb) else $error("time base select wrong");
    property p_hold;
        !ctrl_sh[0] && !wr_cnt && !trig |=> $stable(count_value);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved while stopped");
    property p_step;
        $changed(count_value) && !$past(wr_cnt) && !$past(trig)
            |-> count_value == $past(count_value) + 16'h0001;
    endproperty
    a_step: assert property (p_step) else $error("count step not plus one");
    property p_mask;
        !mask_sh && !$past(mask_sh) |-> !irq;
    endproperty
    a_mask: assert property (p_mask) else $error("irq while masked");
    property p_trig;
        hit && !(ctrl_sh[1] && ctrl_sh[2]) && !wr_cnt |=> count_value == 16'h0000;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger did not clear");
    property p_win;
        wr && paddr == `STC_OFF_LOW && trig |=> count_value[7:0] == $past(pwdata[7:0]);
    endproperty
    a_win: assert property (p_win) else $error("low write lost to trigger");
    property p_osc;
        companion_osc_enable && $past(companion_osc_enable) |-> pin_drive.oe == 2'b00;
    endproperty
    a_osc: assert property (p_osc) else $error("pin driven with oscillator on");
    property p_rd0;
        setup && !pwrite && paddr == `STC_OFF_PORT && companion_osc_enable
            && $past(companion_osc_enable) |=> prdata[5:4] == 2'b00;
    endproperty
    a_rd0: assert property (p_rd0) else $error("pin read not zero");
endmodule

bind stc_timer stc_timer_checker i_stc_timer_checker (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .companion_osc_enable(companion_osc_enable),
    .ccp1_special_trigger(ccp1_special_trigger),
    .ccp2_special_trigger(ccp2_special_trigger), .pin_drive(pin_drive),
    .count_value(count_value), .ccp1_timebase_this(ccp1_timebase_this),
    .ccp2_timebase_this(ccp2_timebase_this));

// ===== stc_far_model.sv
// far side: external count source and two capture/compare trigger units
// assumes requests arrive on pclk; the clock stands low between bursts
`timescale 1ns/100ps
module stc_far_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic [3:0] num,
    input wire logic use_osc,
    input wire logic [1:0] trig_req,
    output logic pin_clk,
    output logic osc_clk,
    output logic [1:0] trig,
    output logic busy
);
    logic [4:0] left;
    logic [2:0] ph;
    logic lvl;
    // slow half period so a sync edge never shares a divider tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left <= 5'h00;
            ph <= 3'h0;
            lvl <= 1'b0;
            trig <= 2'h0;
        end else begin
            trig <= trig_req;
            if (go) begin
                left <= {num, 1'b0};
                ph <= 3'h0;
            end else if (left != 5'h00) begin
                ph <= ph + 3'h1;
                if (ph == 3'h7) begin
                    lvl <= ~lvl;
                    left <= left - 5'h01;
                end
            end
        end
    end
    assign pin_clk = use_osc ? 1'b0 : lvl;
    assign osc_clk = use_osc ? lvl : 1'b0;
    assign busy = left != 5'h00;
endmodule

// ===== test_stc_timer.sv
// self-checking bench for stc_timer over apb with the far-side model
// assumes the checker is bound by its own file
`timescale 1ns/100ps
`include "stc_consts.svh"
module test_stc_timer
    import stc_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, tb1, tb2, pin_clk, osc_clk, busy, err;
    logic osc_en = 1'b0, use_osc = 1'b0, go = 1'b0, pin1 = 1'b1;
    logic [3:0] num = 4'h0;
    logic [1:0] fire = 2'h0, trig_req = 2'h0, trig;
    logic [15:0] count_value;
    stc_pins_t pin_drive;
    int num_errors = 0, checked = 0, cyc = 0;
    stc_timer i_stc_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .pin_in({pin1, pin_clk}), .osc_clk_in(osc_clk),
        .companion_osc_enable(osc_en), .ccp1_special_trigger(trig[0]),
        .ccp2_special_trigger(trig[1]), .pin_drive(pin_drive), .count_value(count_value),
        .ccp1_timebase_this(tb1), .ccp2_timebase_this(tb2));
    stc_far_model i_stc_far_model (.pclk(pclk), .presetn(presetn), .go(go), .num(num),
        .use_osc(use_osc), .trig_req(trig_req), .pin_clk(pin_clk), .osc_clk(osc_clk),
        .trig(trig), .busy(busy));
    initial begin
        forever #50 pclk = ~pclk;
    end
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // fire lines up a trigger with the edge that completes the access
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        trig_req <= fire;
        @(posedge pclk);
        penable <= 1'b1;
        trig_req <= 2'h0;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    task automatic pulses(input logic [3:0] n);
        @(posedge pclk);
        num <= n;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (2) @(posedge pclk);
        while (busy === 1'b1) @(posedge pclk);
        repeat (8) @(posedge pclk);
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        apb(0, `STC_OFF_CTRL, 0);
        chk("ctrl", rd, 32'h0);
        apb(0, `STC_OFF_MASK, 0);
        chk("mask", rd, 32'h0);
        apb(0, `STC_OFF_PORT, 0);
        chk("dir", rd[1:0], 32'h3);
        apb(0, 8'h18, 0);
        chk("unmapped", {err, rd[30:0]}, {1'b1, 31'h0});
        $display("test reset done");
    endtask
    task automatic t_prescale();
        int e;
        for (int ps = 0; ps < 4; ps++) begin
            apb(1, `STC_OFF_CTRL, 32'h04);
            apb(1, `STC_OFF_HIGH, 0);
            apb(1, `STC_OFF_LOW, 0);
            apb(1, `STC_OFF_CTRL, 32'h05 | (ps << 4));
            repeat (256) @(posedge pclk);
            apb(1, `STC_OFF_CTRL, 32'h04);
            e = 259 / (4 << ps);
            chk("rate", count_value >= e - 1 && count_value <= e + 1, 1);
            rd = count_value;
            repeat (20) @(posedge pclk);
            chk("held", count_value, rd);
        end
        $display("test prescale done");
    endtask
    task automatic t_wrap();
        apb(1, `STC_OFF_HIGH, 32'hFF);
        apb(1, `STC_OFF_LOW, 32'hF0);
        chk("count", count_value, 32'hFFF0);
        apb(1, `STC_OFF_MASK, 1);
        apb(1, `STC_OFF_CTRL, 32'h01);
        for (int n = 0; n < 200 && irq !== 1'b1; n++) @(posedge pclk);
        apb(1, `STC_OFF_CTRL, 32'h00);
        chk("wrapped", count_value[15:8], 0);
        apb(0, `STC_OFF_STATUS, 0);
        chk("flag", rd[0], 1);
        apb(1, `STC_OFF_MASK, 0);
        repeat (2) @(posedge pclk);
        chk("irq masked", irq, 0);
        apb(1, `STC_OFF_MASK, 1);
        repeat (2) @(posedge pclk);
        chk("irq", irq, 1);
        apb(1, `STC_OFF_STATUS, 1);
        repeat (2) @(posedge pclk);
        chk("irq cleared", irq, 0);
        $display("test wrap done");
    endtask
    task automatic t_trig();
        apb(1, `STC_OFF_CTRL, 32'h48);
        apb(1, `STC_OFF_HIGH, 1);
        apb(1, `STC_OFF_LOW, 32'h55);
        chk("both units", {tb1, tb2}, 2'b11);
        fire = 2'h1;
        apb(0, `STC_OFF_CTRL, 0);
        chk("cleared", count_value, 0);
        apb(1, `STC_OFF_HIGH, 1);
        apb(1, `STC_OFF_LOW, 32'h77);
        chk("write wins", count_value, 32'h0177);
        fire = 2'h0;
        apb(1, `STC_OFF_CTRL, 32'h08);
        repeat (2) @(posedge pclk);
        chk("unit two", {tb1, tb2}, 2'b01);
        fire = 2'h1;
        apb(0, `STC_OFF_CTRL, 0);
        chk("not cleared", count_value, 32'h0177);
        fire = 2'h2;
        apb(0, `STC_OFF_CTRL, 0);
        fire = 2'h0;
        chk("cleared two", count_value, 0);
        apb(0, `STC_OFF_STATUS, 0);
        chk("no flag", rd[0], 0);
        $display("test trigger done");
    endtask
    task automatic t_ext();
        apb(1, `STC_OFF_CTRL, 32'h00);
        apb(1, `STC_OFF_PORT, 32'h08);
        apb(0, `STC_OFF_PORT, 0);
        chk("pin read", rd[5:4], 2'b10);
        chk("drive", pin_drive, {2'b10, 2'b11});
        apb(1, `STC_OFF_CTRL, 32'h03);
        pulses(5);
        chk("sync", count_value, 4);
        apb(1, `STC_OFF_CTRL, 32'h07);
        pulses(3);
        chk("async", count_value, 7);
        apb(1, `STC_OFF_CTRL, 32'h00);
        @(posedge pclk);
        osc_en <= 1'b1;
        use_osc <= 1'b1;
        apb(1, `STC_OFF_CTRL, 32'h03);
        pulses(3);
        chk("osc", count_value, 9);
        apb(0, `STC_OFF_PORT, 0);
        chk("osc pins", {rd[5:4], pin_drive.oe}, 0);
        $display("test external done");
    endtask
    task automatic t_wide();
        apb(1, `STC_OFF_CTRL, 32'h80);
        apb(1, `STC_OFF_HIGH, 32'hAB);
        chk("buffered", count_value, 9);
        apb(1, `STC_OFF_LOW, 32'hCD);
        chk("wide load", count_value, 32'hABCD);
        apb(0, `STC_OFF_LOW, 0);
        chk("low", rd, 32'hCD);
        apb(1, `STC_OFF_CTRL, 32'h00);
        apb(1, `STC_OFF_HIGH, 32'h77);
        chk("narrow", count_value, 32'h77CD);
        apb(1, `STC_OFF_CTRL, 32'h80);
        apb(0, `STC_OFF_HIGH, 0);
        chk("buffer read", rd, 32'hAB);
        $display("test wide done");
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_prescale();
        t_wrap();
        t_trig();
        t_ext();
        t_wide();
        tally_and_finish();
    end
endmodule
